// >>> rtl/esq_pkg.sv
// Constants and types for the egress queue scheduler and credit shaper.
// Assumes one instance per switch port and a plain one-cycle register port.
package esq_pkg;
   localparam int NQ = 4;
   localparam int ADDR_W = 16;
   localparam int DATA_W = 16;
   localparam int CR_W = 34;
   localparam int FRAC_W = 16;

   localparam logic [15:0] OFF_QINDEX = 16'h0900;
   localparam logic [15:0] OFF_SCHED_CTRL = 16'h0914;
   localparam logic [15:0] OFF_RR_WEIGHT = 16'h0915;
   localparam logic [15:0] OFF_HIGH_MARK = 16'h0916;
   localparam logic [15:0] OFF_LOW_MARK = 16'h0918;
   localparam logic [15:0] OFF_INCREMENT = 16'h091a;
   localparam logic [15:0] OFF_QCOUNT = 16'h0920;
   localparam logic [15:0] OFF_CREDIT = 16'h0922;

   localparam int SCHED_LSB = 6;
   localparam int SHAPER_LSB = 4;
   localparam int WEIGHT_W = 7;

   localparam logic [1:0] RST_QINDEX = 2'h0;
   localparam logic [WEIGHT_W-1:0] RST_WEIGHT = 7'h01;
   localparam logic [15:0] RST_HIGH_MARK = 16'h0534;
   localparam logic [15:0] RST_LOW_MARK = 16'h05f2;
   localparam logic [15:0] RST_INCREMENT = 16'h2000;

   typedef enum logic [1:0] {
      ESQ_STRICT = 2'b00,
      ESQ_WRR = 2'b10
   } esq_sched_t;

   typedef enum logic [1:0] {
      ESQ_NO_SHAPE = 2'b00,
      ESQ_CBS = 2'b01
   } esq_shape_t;

   typedef enum logic [1:0] {
      ESQ_ONE_Q = 2'b00,
      ESQ_TWO_Q = 2'b01,
      ESQ_FOUR_Q = 2'b10
   } esq_qcount_t;

   localparam logic [1:0] RST_SCHED = 2'b10;
   localparam logic [1:0] RST_SHAPER = 2'b00;
   localparam logic [1:0] RST_QCOUNT = 2'b10;

   localparam logic [CR_W-1:0] CREDIT_BYTE = 34'h0_0001_0000;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } esq_bus_req_t;
endpackage

// >>> rtl/esq_scheduler.sv
// Egress queue scheduler with per-queue credit based shaper for one switch port.
// Assumes a same-clock register master and same-clock queue status from the queue manager.
//
// Contract
// - Settings per queue, addressed via queue index
// - Mode bits 7:6: 00 strict, 10 WRR
// - Mode matters only with two/four queues
// - Strict: higher queue number served first
// - WRR: up to weight packets, then next
// - Shaper bits 5:4: 00 off, 01 CBS
// - Seven-bit weight per queue, reset one
// - Single queue ignores round-robin weights
// - Sixteen-bit high water mark, reset 0x0534
// - Sixteen-bit low water mark, reset 0x05f2
// - Sixteen-bit credit increment, reset 0x2000
// - Index bits 1:0 pick queue, reset zero
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
module esq_scheduler (
   input wire logic mclk,
   input wire logic rst_n,
   input wire esq_pkg::esq_bus_req_t bus,
   output logic [esq_pkg::DATA_W-1:0] rd_data,
   input wire logic [esq_pkg::NQ-1:0] q_pending,
   input wire logic sched_req,
   input wire logic tx_active,
   input wire logic tx_byte,
   output logic grant_valid,
   output logic [1:0] grant_queue
);
   logic [1:0] q_index;
   logic [1:0] sched_mode [esq_pkg::NQ];
   logic [1:0] shaper_mode [esq_pkg::NQ];
   logic [esq_pkg::WEIGHT_W-1:0] weight [esq_pkg::NQ];
   logic [15:0] high_mark [esq_pkg::NQ];
   logic [15:0] low_mark [esq_pkg::NQ];
   logic [15:0] increment [esq_pkg::NQ];
   logic [1:0] q_count;
   logic signed [esq_pkg::CR_W-1:0] credit [esq_pkg::NQ];
   logic signed [esq_pkg::CR_W-1:0] next_credit [esq_pkg::NQ];
   logic [esq_pkg::WEIGHT_W-1:0] sent_cnt;
   logic [1:0] cur_q;

   // Highest set bit of a queue mask
   function automatic logic [1:0] pick_high(input logic [3:0] m);
      logic [1:0] r;
      r = 2'h0;
      for (int i = 0; i < 4; i++) begin
         if (m[i]) begin
            r = 2'(i);
         end
      end
      return r;
   endfunction

   // First set bit after the current queue, wrapping
   function automatic logic [1:0] pick_next(input logic [3:0] m, input logic [1:0] c);
      logic [1:0] r;
      logic [1:0] k;
      r = c;
      for (int i = 3; i >= 1; i--) begin
         k = c + 2'(i);
         if (m[k]) begin
            r = k;
         end
      end
      return r;
   endfunction

   // Keep a credit between the negative low mark and the high mark
   function automatic logic signed [esq_pkg::CR_W-1:0] clamp_credit(
      input logic signed [esq_pkg::CR_W-1:0] v, input logic [15:0] hi, input logic [15:0] lo);
      logic signed [esq_pkg::CR_W-1:0] top;
      logic signed [esq_pkg::CR_W-1:0] bot;
      top = $signed({2'b00, hi, 16'h0000});
      bot = -$signed({2'b00, lo, 16'h0000});
      if (v > top) begin
         return top;
      end
      if (v < bot) begin
         return bot;
      end
      return v;
   endfunction

   // Register decode
   wire wr_qindex = bus.wr && bus.addr == esq_pkg::OFF_QINDEX;
   wire wr_ctrl = bus.wr && bus.addr == esq_pkg::OFF_SCHED_CTRL;
   wire wr_weight = bus.wr && bus.addr == esq_pkg::OFF_RR_WEIGHT;
   wire wr_high = bus.wr && bus.addr == esq_pkg::OFF_HIGH_MARK;
   wire wr_low = bus.wr && bus.addr == esq_pkg::OFF_LOW_MARK;
   wire wr_incr = bus.wr && bus.addr == esq_pkg::OFF_INCREMENT;
   wire wr_qcount = bus.wr && bus.addr == esq_pkg::OFF_QCOUNT;

   // Indexed read view, reserved bits forced to zero
   wire [15:0] rd_ctrl = {8'h00, sched_mode[q_index], shaper_mode[q_index], 4'h0};
   wire [15:0] rd_weight = {9'h000, weight[q_index]};
   wire [15:0] rd_credit = credit[q_index][31:16];
   wire [15:0] rd_mux =
      (bus.addr == esq_pkg::OFF_QINDEX) ? {14'h0000, q_index} :
      (bus.addr == esq_pkg::OFF_SCHED_CTRL) ? rd_ctrl :
      (bus.addr == esq_pkg::OFF_RR_WEIGHT) ? rd_weight :
      (bus.addr == esq_pkg::OFF_HIGH_MARK) ? high_mark[q_index] :
      (bus.addr == esq_pkg::OFF_LOW_MARK) ? low_mark[q_index] :
      (bus.addr == esq_pkg::OFF_INCREMENT) ? increment[q_index] :
      (bus.addr == esq_pkg::OFF_QCOUNT) ? {14'h0000, q_count} :
      (bus.addr == esq_pkg::OFF_CREDIT) ? rd_credit : 16'h0000;

   // Enabled queues and eligibility
   wire single_q = q_count == esq_pkg::ESQ_ONE_Q;
   wire [3:0] en_mask = single_q ? 4'h1 : (q_count == esq_pkg::ESQ_TWO_Q) ? 4'h3 : 4'hf;
   logic [3:0] credit_ok;
   logic [3:0] is_strict;
   always_comb begin
      for (int q = 0; q < esq_pkg::NQ; q++) begin
         credit_ok[q] = shaper_mode[q] != esq_pkg::ESQ_CBS || !credit[q][esq_pkg::CR_W-1];
         is_strict[q] = sched_mode[q] == esq_pkg::ESQ_STRICT;
      end
   end
   wire [3:0] elig = q_pending & en_mask & credit_ok;
   wire [3:0] strict_elig = elig & is_strict;
   wire [3:0] wrr_elig = elig & ~is_strict;

   // Queue choice
   wire stay_cur = wrr_elig[cur_q] && sent_cnt < weight[cur_q];
   wire [1:0] wrr_pick = stay_cur ? cur_q : pick_next(wrr_elig, cur_q);
   wire [1:0] pick =
      single_q ? 2'h0 :
      (strict_elig != 4'h0) ? pick_high(strict_elig) :
      wrr_pick;
   wire do_grant = sched_req && elig != 4'h0;
   wire same_run = !single_q && !is_strict[pick] && pick == cur_q && stay_cur;
   wire [esq_pkg::WEIGHT_W-1:0] next_sent = same_run ? sent_cnt + 7'h01 : 7'h01;

   // Credit evolution per queue
   always_comb begin
      for (int q = 0; q < esq_pkg::NQ; q++) begin
         next_credit[q] = credit[q];
         if (shaper_mode[q] != esq_pkg::ESQ_CBS) begin
            next_credit[q] = '0;
         end else if (tx_active && grant_queue == 2'(q)) begin
            if (tx_byte) begin
               next_credit[q] = credit[q] - $signed(esq_pkg::CREDIT_BYTE);
            end
         end else if (q_pending[q]) begin
            next_credit[q] = credit[q] + $signed({18'h00000, increment[q]});
         end else if (credit[q] > 0) begin
            next_credit[q] = '0;
         end else if (credit[q] < 0) begin
            next_credit[q] = credit[q] + $signed({18'h00000, increment[q]});
            if (next_credit[q] > 0) begin
               next_credit[q] = '0;
            end
         end
         next_credit[q] = clamp_credit(next_credit[q], high_mark[q], low_mark[q]);
      end
   end

   // Global registers and read data
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         q_index <= esq_pkg::RST_QINDEX;
         q_count <= esq_pkg::RST_QCOUNT;
         rd_data <= '0;
      end else begin
         if (wr_qindex) begin
            q_index <= bus.wdata[1:0];
         end
         if (wr_qcount) begin
            q_count <= bus.wdata[1:0];
         end
         rd_data <= bus.rd ? rd_mux : 16'h0000;
      end
   end

   // Indexed per-queue settings
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         for (int q = 0; q < esq_pkg::NQ; q++) begin
            sched_mode[q] <= esq_pkg::RST_SCHED;
            shaper_mode[q] <= esq_pkg::RST_SHAPER;
            weight[q] <= esq_pkg::RST_WEIGHT;
            high_mark[q] <= esq_pkg::RST_HIGH_MARK;
            low_mark[q] <= esq_pkg::RST_LOW_MARK;
            increment[q] <= esq_pkg::RST_INCREMENT;
         end
      end else begin
         if (wr_ctrl) begin
            sched_mode[q_index] <= bus.wdata[esq_pkg::SCHED_LSB+:2];
            shaper_mode[q_index] <= bus.wdata[esq_pkg::SHAPER_LSB+:2];
         end
         if (wr_weight) begin
            weight[q_index] <= bus.wdata[esq_pkg::WEIGHT_W-1:0];
         end
         if (wr_high) begin
            high_mark[q_index] <= bus.wdata;
         end
         if (wr_low) begin
            low_mark[q_index] <= bus.wdata;
         end
         if (wr_incr) begin
            increment[q_index] <= bus.wdata;
         end
      end
   end

   // Shaper credits
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         for (int q = 0; q < esq_pkg::NQ; q++) begin
            credit[q] <= '0;
         end
      end else begin
         for (int q = 0; q < esq_pkg::NQ; q++) begin
            credit[q] <= next_credit[q];
         end
      end
   end

   // Grants
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         grant_valid <= 1'b0;
         grant_queue <= 2'h0;
         cur_q <= 2'h0;
         sent_cnt <= '0;
      end else begin
         grant_valid <= do_grant;
         if (do_grant) begin
            grant_queue <= pick;
            cur_q <= pick;
            sent_cnt <= next_sent;
         end
      end
   end
endmodule

// >>> sim/esq_sva.sv
// Port checker for the egress scheduler.
// Assumes a bind to esq_scheduler.
`timescale 1ns/1ps
module esq_sva (
   input wire logic mclk,
   input wire logic rst_n,
   input wire esq_pkg::esq_bus_req_t bus,
   input wire logic [esq_pkg::DATA_W-1:0] rd_data,
   input wire logic [esq_pkg::NQ-1:0] q_pending,
   input wire logic sched_req,
   input wire logic grant_valid,
   input wire logic [1:0] grant_queue
);
   logic sq;
   logic [3:0] pq;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         sq <= 1'b0;
         pq <= 4'h0;
      end else begin
         sq <= sched_req;
         pq <= q_pending;
      end
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   property p_rd_idle; !bus.rd |=> rd_data == 16'h0; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside read");
   property p_ctl_rsv; bus.rd && bus.addr == 16'h0914 |=> (rd_data & 16'hff0f) == 16'h0; endproperty
   a_ctl_rsv: assert property (p_ctl_rsv) else $error("control reserved bits set");
   property p_wt_rsv; bus.rd && bus.addr == 16'h0915 |=> rd_data[15:7] == 9'h0; endproperty
   a_wt_rsv: assert property (p_wt_rsv) else $error("weight reserved bits set");
   property p_idx_rsv; bus.rd && bus.addr == 16'h0900 |=> rd_data[15:2] == 14'h0; endproperty
   a_idx_rsv: assert property (p_idx_rsv) else $error("index reserved bits set");
   property p_unmap; bus.rd && bus.addr == 16'h0930 |=> rd_data == 16'h0; endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
   property p_gnt_src; grant_valid |-> sq && pq[grant_queue]; endproperty
   a_gnt_src: assert property (p_gnt_src) else $error("grant without pending queue");
   property p_gnt_none; sched_req && q_pending == 4'h0 |=> !grant_valid; endproperty
   a_gnt_none: assert property (p_gnt_none) else $error("grant with no queue");
   property p_gq_hold; !grant_valid |-> $stable(grant_queue); endproperty
   a_gq_hold: assert property (p_gq_hold) else $error("grant queue moved");
   c_gnt: cover property (grant_valid);
   c_top: cover property (grant_valid && grant_queue == 2'h3);
   c_rd: cover property (bus.rd);
endmodule
bind esq_scheduler esq_sva u_sva (.mclk(mclk), .rst_n(rst_n), .bus(bus), .rd_data(rd_data),
   .q_pending(q_pending), .sched_req(sched_req), .grant_valid(grant_valid), .grant_queue(grant_queue));

// >>> sim/testbench.sv
// Self-checking bench: registers, strict, round robin, single queue, shaper.
// Assumes esq_scheduler and its checker are compiled first.
`timescale 1ns/1ps
module testbench;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   esq_pkg::esq_bus_req_t bus = '0;
   logic [15:0] rd_data;
   logic [3:0] q_pending = 4'h0;
   logic sched_req = 1'b0;
   logic tx_active = 1'b0;
   logic tx_byte = 1'b0;
   logic grant_valid;
   logic [1:0] grant_queue;
   int n_mismatch = 0;
   int cmp_count = 0;
   logic [15:0] m [4][5];
   logic [15:0] offs [5] = '{16'h0914, 16'h0915, 16'h0916, 16'h0918, 16'h091a};
   logic [15:0] msk [5] = '{16'h00f0, 16'h007f, 16'hffff, 16'hffff, 16'hffff};
   always #20 mclk = ~mclk;
   esq_scheduler dut (.mclk(mclk), .rst_n(rst_n), .bus(bus), .rd_data(rd_data), .q_pending(q_pending),
      .sched_req(sched_req), .tx_active(tx_active), .tx_byte(tx_byte), .grant_valid(grant_valid),
      .grant_queue(grant_queue));
   task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
      cmp_count++;
      if (s !== e) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      bus <= '{a, d, 1'b1, 1'b0};
      @(posedge mclk);
      bus <= '0;
      @(posedge mclk);
   endtask
   task automatic rd(input logic [15:0] a, input logic [15:0] e);
      bus <= '{a, 16'h0, 1'b0, 1'b1};
      @(posedge mclk);
      bus <= '0;
      @(negedge mclk);
      chk("rd_data", rd_data, e);
      @(posedge mclk);
   endtask
   task automatic grant(input logic ev, output logic [1:0] g);
      sched_req <= 1'b1;
      @(posedge mclk);
      sched_req <= 1'b0;
      @(negedge mclk);
      chk("grant_valid", 16'(grant_valid), 16'(ev));
      g = grant_queue;
      @(posedge mclk);
   endtask
   task automatic conclude();
      if (n_mismatch == 0 && cmp_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge mclk);
      n_mismatch++;
      conclude();
   end
   initial begin
      logic [1:0] g;
      logic [15:0] d;
      int p;
      int run;
      int sw;
      void'($urandom(32'hef532a7c));
      for (int q = 0; q < 4; q++) m[q] = '{16'h0080, 16'h0001, 16'h0534, 16'h05f2, 16'h2000};
      repeat (2) @(posedge mclk);
      rst_n <= 1'b1;
      @(posedge mclk);
      rd(16'h0900, 16'h0);
      for (int q = 0; q < 4; q++) begin
         wr(16'h0900, 16'(q));
         for (int r = 0; r < 5; r++) begin
            rd(offs[r], m[q][r]);
            d = 16'($urandom);
            if (r == 1 && d[6:0] == 7'h0) d[0] = 1'b1;
            m[q][r] = d & msk[r];
            wr(offs[r], d);
         end
      end
      for (int q = 0; q < 4; q++) begin
         wr(16'h0900, 16'hfffc | 16'(q));
         rd(16'h0900, 16'(q));
         for (int r = 0; r < 5; r++) rd(offs[r], m[q][r]);
      end
      rd(16'h0930, 16'h0);
      for (int q = 0; q < 4; q++) begin
         wr(16'h0900, 16'(q));
         wr(16'h0914, 16'h0000);
         wr(16'h0915, 16'(q + 1));
      end
      repeat (8) begin
         d = 16'($urandom_range(15, 1));
         q_pending <= d[3:0];
         grant(1'b1, g);
         chk("strict", 16'(g), d[3] ? 16'h3 : d[2] ? 16'h2 : d[1] ? 16'h1 : 16'h0);
      end
      for (int q = 0; q < 4; q++) begin
         wr(16'h0900, 16'(q));
         wr(16'h0914, 16'h0080);
      end
      q_pending <= 4'hf;
      p = -1;
      run = 0;
      sw = 0;
      for (int i = 0; i < 24; i++) begin
         grant(1'b1, g);
         if (p >= 0 && g != p) begin
            if (sw != 0) chk("wrr turn", 16'(run), 16'(p + 1));
            chk("wrr next", 16'(g), 16'((p + 1) % 4));
            sw = 1;
            run = 0;
         end
         run++;
         p = g;
      end
      wr(16'h0920, 16'h0000);
      grant(1'b1, g);
      chk("single", 16'(g), 16'h0);
      q_pending <= 4'h8;
      grant(1'b0, g);
      wr(16'h0900, 16'h0000);
      wr(16'h0914, 16'h0010);
      wr(16'h0916, 16'h0004);
      wr(16'h0918, 16'h0005);
      wr(16'h091a, 16'h2000);
      q_pending <= 4'h1;
      repeat (80) @(posedge mclk);
      rd(16'h0922, 16'h0004);
      grant(1'b1, g);
      tx_active <= 1'b1;
      tx_byte <= 1'b1;
      repeat (10) @(posedge mclk);
      tx_active <= 1'b0;
      tx_byte <= 1'b0;
      rd(16'h0922, 16'hfffb);
      grant(1'b0, g);
      repeat (80) @(posedge mclk);
      grant(1'b1, g);
      conclude();
   end
endmodule
